//--- vca_pkg.sv
package vca_pkg;

  // ****************************************************************
  // Register map (byte offsets on the APB window)
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL     = 8'h00; // Global enable
  localparam logic [7:0] OFS_IRQ_STAT = 8'h04; // Sticky events, W1C
  localparam logic [7:0] OFS_IRQ_MASK = 8'h08; // Event enables
  localparam logic [7:0] OFS_DROP_CNT = 8'h0c; // Discard counter, RO
  localparam logic [7:0] OFS_TBL_IDX  = 8'h10; // Table entry pointer
  localparam logic [7:0] OFS_TBL_VID  = 8'h14; // Staged tag pair
  localparam logic [7:0] OFS_TBL_CFG  = 8'h18; // Staged entry options
  localparam logic [7:0] OFS_TBL_SID0 = 8'h1c; // Staged string, low
  localparam logic [7:0] OFS_TBL_SID1 = 8'h20; // Staged string, mid
  localparam logic [7:0] OFS_TBL_SID2 = 8'h24; // Staged string, high
  localparam logic [7:0] OFS_PREFIX   = 8'h28; // Service id prefix
  localparam logic [7:0] OFS_TBL_CMD  = 8'h2c; // Bit 0 commits entry

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int CTRL_EN_BIT     = 0;
  localparam int CFG_VALID_BIT   = 0;
  localparam int CFG_DHCP_BIT    = 1;
  localparam int CFG_PPPOE_BIT   = 2;
  localparam int CFG_MODE_LSB    = 4;
  localparam int CFG_PORT_LSB    = 8;
  localparam int VID_INNER_LSB   = 0;
  localparam int VID_OUTER_LSB   = 16;
  localparam int IRQ_DROP_BIT    = 0;
  localparam int IRQ_RELAY_BIT   = 1;
  localparam int IRQ_REJECT_BIT  = 2;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [2:0]  MASK_RST = 3'h0;

  // ****************************************************************
  // Protocol constants
  // ****************************************************************
  localparam logic [7:0]  OPT82_CODE   = 8'h52;  // Relay option 82
  localparam logic [11:0] INNER_MAX    = 12'hfa0; // 4000 per circuit
  localparam logic [11:0] VID_RSVD_HI  = 12'hfff;
  localparam logic [7:0]  OPT_NEW_LEN  = 8'h13;  // Hdr 2 + sub 2 + 15
  localparam logic [7:0]  CIRC_ID_LEN  = 8'h00;  // Always left empty

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {MODE_ACCESS, MODE_PASS, MODE_MANY} vca_mode_t;
  typedef enum logic [1:0] {KIND_OTHER, KIND_DHCP_DISC, KIND_PADI}
    vca_kind_t;

  // Parsed frame header entering the block
  typedef struct packed {
    logic        dir;        // 0 from user side, 1 from network side
    logic [3:0]  port;       // User port number
    logic        has_outer;  // Outer tag present
    logic [11:0] outer_vid;
    logic        has_inner;  // Inner tag present
    logic [11:0] inner_vid;
    vca_kind_t   kind;
    logic [7:0]  opt_len;    // Existing relay option bytes, 0 if none
    logic [15:0] pkt_len;
    logic [5:0]  dscp;
  } vca_hdr_in_t;

  // Edited frame header leaving the block
  typedef struct packed {
    logic         drop;
    logic         dir;
    logic [3:0]   port;
    logic         tag_outer;
    logic [11:0]  outer_vid;
    logic         tag_inner;
    logic [11:0]  inner_vid;
    vca_kind_t    kind;
    logic         relay;       // Relay option written
    logic [7:0]   opt_code;
    logic [7:0]   opt_len;
    logic [7:0]   circ_id_len;
    logic [119:0] remote_identifier;   // Prefix then circuit string
    logic [15:0]  pkt_len;
    logic         csum_fix;    // Checksum must be recomputed
    logic [5:0]   dscp;
  } vca_hdr_out_t;

endpackage : vca_pkg

//--- vca_top.sv
`timescale 1ns/10ps
module vca_top #(
  parameter int NCIRC = 16                 // Circuit table depth
) (
  input  wire logic                  clock_i,
  input  wire logic                  resetn_i,
  input  wire logic                  ce_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [7:0]            paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic      [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  input  wire logic                  hdr_valid_i,
  input  wire vca_pkg::vca_hdr_in_t  hdr_i,
  output logic                       hdr_valid_o,
  output vca_pkg::vca_hdr_out_t      hdr_o,
  output logic                       irq_o
);

  localparam int IW = $clog2(NCIRC);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_q1;                          // First stage, read only by q2
  logic rst_n;                           // Synchronised reset

  // Async assert, two-stage release
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Tag value usable as a circuit identifier
  function automatic logic vid_ok(input logic [11:0] vid);
    vid_ok = (vid != 12'h000) && (vid != vca_pkg::VID_RSVD_HI);
  endfunction : vid_ok

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic              enable;             // Global forwarding enable
  logic [2:0]        irq_stat;           // Sticky events
  logic [2:0]        irq_mask;           // Event enables
  logic [31:0]       drop_cnt;           // Discard counter
  logic [IW-1:0]     tbl_idx;            // Entry pointer
  logic [31:0]       stg_vid;            // Staged tag pair
  logic [31:0]       stg_cfg;            // Staged options
  logic [95:0]       stg_sid;            // Staged circuit string
  logic [23:0]       prefix;             // Service id prefix

  // Circuit table, flip-flops addressed by index
  logic              t_valid [NCIRC];
  logic              t_dhcp  [NCIRC];
  logic              t_pppoe [NCIRC];
  vca_pkg::vca_mode_t t_mode [NCIRC];
  logic [3:0]        t_port  [NCIRC];
  logic [11:0]       t_outer [NCIRC];
  logic [11:0]       t_inner [NCIRC];
  logic [95:0]       t_sid   [NCIRC];

  // ****************************************************************
  // APB slave
  // ****************************************************************
  logic acc;                             // Access completes this edge
  logic wr;                              // Write completes this edge
  logic mapped;                          // Address decodes
  logic commit;                          // Table commit request
  logic stg_inner_ok;                    // Staged inner tag legal
  logic stg_dup;                         // Staged pair already used
  logic commit_ok;                       // Commit accepted
  logic commit_bad;                      // Commit refused

  assign acc = psel_i && penable_i && pready_o;
  assign wr  = acc && pwrite_i;

  // Decode of the mapped word offsets
  always_comb begin
    case (paddr_i)
      vca_pkg::OFS_CTRL, vca_pkg::OFS_IRQ_STAT, vca_pkg::OFS_IRQ_MASK,
      vca_pkg::OFS_DROP_CNT, vca_pkg::OFS_TBL_IDX, vca_pkg::OFS_TBL_VID,
      vca_pkg::OFS_TBL_CFG, vca_pkg::OFS_TBL_SID0, vca_pkg::OFS_TBL_SID1,
      vca_pkg::OFS_TBL_SID2, vca_pkg::OFS_PREFIX,
      vca_pkg::OFS_TBL_CMD: mapped = 1'b1;
      default:              mapped = 1'b0;
    endcase
  end

  // One wait state: ready and data rise one cycle into access
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else if (ce_i) begin
      pready_o  <= psel_i && penable_i && !pready_o;
      pslverr_o <= psel_i && penable_i && !pready_o && !mapped;
      if (psel_i && penable_i && !pready_o && !pwrite_i) begin
        case (paddr_i)
          vca_pkg::OFS_CTRL:     prdata_o <= {31'h0, enable};
          vca_pkg::OFS_IRQ_STAT: prdata_o <= {29'h0, irq_stat};
          vca_pkg::OFS_IRQ_MASK: prdata_o <= {29'h0, irq_mask};
          vca_pkg::OFS_DROP_CNT: prdata_o <= drop_cnt;
          vca_pkg::OFS_TBL_IDX:  prdata_o <= 32'(tbl_idx);
          vca_pkg::OFS_TBL_VID:  prdata_o <= stg_vid;
          vca_pkg::OFS_TBL_CFG:  prdata_o <= stg_cfg;
          vca_pkg::OFS_TBL_SID0: prdata_o <= stg_sid[31:0];
          vca_pkg::OFS_TBL_SID1: prdata_o <= stg_sid[63:32];
          vca_pkg::OFS_TBL_SID2: prdata_o <= stg_sid[95:64];
          vca_pkg::OFS_PREFIX:   prdata_o <= {8'h00, prefix};
          default:               prdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control and staging registers
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      enable   <= vca_pkg::CTRL_RST[vca_pkg::CTRL_EN_BIT];
      irq_mask <= vca_pkg::MASK_RST;
      tbl_idx  <= '0;
      stg_vid  <= 32'h0000_0000;
      stg_cfg  <= 32'h0000_0000;
      stg_sid  <= '0;
      prefix   <= 24'h000000;
    end else if (ce_i && wr) begin
      case (paddr_i)
        vca_pkg::OFS_CTRL:     enable   <= pwdata_i[vca_pkg::CTRL_EN_BIT];
        vca_pkg::OFS_IRQ_MASK: irq_mask <= pwdata_i[2:0];
        vca_pkg::OFS_TBL_IDX:  tbl_idx  <= pwdata_i[IW-1:0];
        vca_pkg::OFS_TBL_VID:  stg_vid  <= pwdata_i;
        vca_pkg::OFS_TBL_CFG:  stg_cfg  <= pwdata_i;
        vca_pkg::OFS_TBL_SID0: stg_sid[31:0]  <= pwdata_i;
        vca_pkg::OFS_TBL_SID1: stg_sid[63:32] <= pwdata_i;
        vca_pkg::OFS_TBL_SID2: stg_sid[95:64] <= pwdata_i;
        vca_pkg::OFS_PREFIX:   prefix   <= pwdata_i[23:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Table commit checks
  // ****************************************************************
  logic [11:0] s_outer;                  // Staged outer tag
  logic [11:0] s_inner;                  // Staged inner tag
  vca_pkg::vca_mode_t s_mode;            // Staged mode

  assign s_outer = stg_vid[vca_pkg::VID_OUTER_LSB +: 12];
  assign s_inner = stg_vid[vca_pkg::VID_INNER_LSB +: 12];
  assign s_mode  = vca_pkg::vca_mode_t'(stg_cfg[vca_pkg::CFG_MODE_LSB +: 2]);
  assign commit  = wr && (paddr_i == vca_pkg::OFS_TBL_CMD) && pwdata_i[0];
  // Inner tag in 1..4000 for access circuits only
  assign stg_inner_ok = (s_mode != vca_pkg::MODE_ACCESS) ||
    (vid_ok(s_inner) && (s_inner <= vca_pkg::INNER_MAX));

  // Another live entry with the same tag pair would merge circuits
  always_comb begin
    stg_dup = 1'b0;
    for (int i = 0; i < NCIRC; i++) begin
      if (t_valid[i] && (i != int'(tbl_idx)) && t_outer[i] == s_outer &&
          (t_mode[i] != vca_pkg::MODE_ACCESS ||
           s_mode != vca_pkg::MODE_ACCESS || t_inner[i] == s_inner))
        stg_dup = 1'b1;
    end
  end

  // A disabled entry skips all checks so it can always be retired
  assign commit_bad = commit && stg_cfg[vca_pkg::CFG_VALID_BIT] &&
    (!stg_inner_ok || stg_dup || !vid_ok(s_outer));
  assign commit_ok  = commit && !commit_bad;

  // Table write, relay options off until set
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NCIRC; i++) begin
        t_valid[i] <= 1'b0;
        t_dhcp[i]  <= 1'b0;
        t_pppoe[i] <= 1'b0;
        t_mode[i]  <= vca_pkg::MODE_ACCESS;
        t_port[i]  <= 4'h0;
        t_outer[i] <= 12'h000;
        t_inner[i] <= 12'h000;
        t_sid[i]   <= '0;
      end
    end else if (ce_i && commit_ok) begin
      t_valid[tbl_idx] <= stg_cfg[vca_pkg::CFG_VALID_BIT];
      t_dhcp[tbl_idx]  <= stg_cfg[vca_pkg::CFG_DHCP_BIT];
      t_pppoe[tbl_idx] <= stg_cfg[vca_pkg::CFG_PPPOE_BIT];
      t_mode[tbl_idx]  <= s_mode;
      t_port[tbl_idx]  <= stg_cfg[vca_pkg::CFG_PORT_LSB +: 4];
      t_outer[tbl_idx] <= s_outer;
      t_inner[tbl_idx] <= s_inner;
      t_sid[tbl_idx]   <= stg_sid;
    end
  end

  // ****************************************************************
  // Classification
  // ****************************************************************
  logic          hit;                    // Frame belongs to a circuit
  logic [IW-1:0] hidx;                   // Matching entry
  logic          drop_c;                 // Frame discarded
  logic          relay_c;                // Relay option to be written
  logic          match;                  // Per-entry scratch

  // First matching live entry wins
  always_comb begin
    hit   = 1'b0;
    hidx  = '0;
    match = 1'b0;
    for (int i = 0; i < NCIRC; i++) begin
      if (!hdr_i.dir) begin
        // Passthrough and many-to-one entries own the whole port
        match = t_port[i] == hdr_i.port &&
          (t_mode[i] != vca_pkg::MODE_ACCESS ||
           (hdr_i.has_inner && hdr_i.inner_vid == t_inner[i]));
      end else begin
        // Outer tag must be present, legal and agreed
        match = hdr_i.has_outer && vid_ok(hdr_i.outer_vid) &&
          hdr_i.outer_vid == t_outer[i] &&
          (t_mode[i] != vca_pkg::MODE_ACCESS ||
           (hdr_i.has_inner && hdr_i.inner_vid == t_inner[i]));
      end
      if (!hit && t_valid[i] && match) begin
        hit  = 1'b1;
        hidx = IW'(i);
      end
    end
  end

  assign drop_c  = !hit || !enable;
  // Relay only on upstream access circuits, per protocol
  assign relay_c = !drop_c && !hdr_i.dir &&
    t_mode[hidx] == vca_pkg::MODE_ACCESS &&
    ((hdr_i.kind == vca_pkg::KIND_DHCP_DISC && t_dhcp[hidx]) ||
     (hdr_i.kind == vca_pkg::KIND_PADI && t_pppoe[hidx]));

  // ****************************************************************
  // Header edit
  // ****************************************************************
  vca_pkg::vca_hdr_out_t next_hdr;       // Edited header

  always_comb begin
    next_hdr             = '0;
    next_hdr.drop        = drop_c;
    next_hdr.dir         = hdr_i.dir;
    next_hdr.port        = hdr_i.port;
    next_hdr.tag_outer   = hdr_i.has_outer;
    next_hdr.outer_vid   = hdr_i.outer_vid;
    next_hdr.tag_inner   = hdr_i.has_inner;
    next_hdr.inner_vid   = hdr_i.inner_vid;
    next_hdr.kind        = hdr_i.kind;
    next_hdr.opt_len     = hdr_i.opt_len;
    next_hdr.pkt_len     = hdr_i.pkt_len;
    next_hdr.dscp        = hdr_i.dscp;
    if (!drop_c && !hdr_i.dir) begin
      // Upstream gets the circuit's outer tag
      next_hdr.tag_outer = 1'b1;
      next_hdr.outer_vid = t_outer[hidx];
      next_hdr.tag_inner = t_mode[hidx] == vca_pkg::MODE_ACCESS;
      next_hdr.inner_vid = t_inner[hidx];
    end
    if (!drop_c && hdr_i.dir && t_mode[hidx] == vca_pkg::MODE_PASS)
      next_hdr.tag_outer = 1'b0;
    if (relay_c) begin
      // Customer option replaced whole: circuit empty, remote ours
      next_hdr.relay       = 1'b1;
      next_hdr.opt_code    = vca_pkg::OPT82_CODE;
      next_hdr.circ_id_len = vca_pkg::CIRC_ID_LEN;
      next_hdr.remote_identifier   = {prefix, t_sid[hidx]};
      next_hdr.opt_len     = vca_pkg::OPT_NEW_LEN;
      next_hdr.pkt_len     = hdr_i.pkt_len - 16'(hdr_i.opt_len) +
                             16'(vca_pkg::OPT_NEW_LEN);
      next_hdr.csum_fix    = 1'b1;
    end
  end

  // Registered header output
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      hdr_valid_o <= 1'b0;
      hdr_o       <= '0;
    end else if (ce_i) begin
      hdr_valid_o <= hdr_valid_i;
      if (hdr_valid_i)
        hdr_o <= next_hdr;
    end
  end

  // ****************************************************************
  // Counters and interrupts
  // ****************************************************************
  logic [2:0] ev;                        // Events this cycle
  logic [2:0] clr;                       // Write-one-to-clear bits

  assign ev  = {commit_bad, hdr_valid_i && relay_c, hdr_valid_i && drop_c};
  assign clr = (wr && paddr_i == vca_pkg::OFS_IRQ_STAT) ? pwdata_i[2:0]
                                                       : 3'h0;

  // Every discard counts, wraps silently at the top
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n)
      drop_cnt <= 32'h0000_0000;
    else if (ce_i && hdr_valid_i && drop_c)
      drop_cnt <= drop_cnt + 32'h0000_0001;
  end

  // Set beats clear so no event is lost
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= 3'h0;
      irq_o    <= 1'b0;
    end else if (ce_i) begin
      irq_stat <= (irq_stat & ~clr) | ev;
      irq_o    <= |(((irq_stat & ~clr) | ev) & irq_mask);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic go;                              // Frame accepted this edge
  assign go = ce_i && hdr_valid_i;

  property p_drop_cnt;
    @(posedge clock_i) disable iff (!rst_n)
    go && drop_c |=> drop_cnt == $past(drop_cnt) + 32'h0000_0001;
  endproperty
  a_drop_cnt: assert property (p_drop_cnt)
    else $error("drop counter missed a discard");

  property p_dhcp_relay;
    @(posedge clock_i) disable iff (!rst_n)
    go && !drop_c && !hdr_i.dir && hdr_i.kind == vca_pkg::KIND_DHCP_DISC &&
    t_mode[hidx] == vca_pkg::MODE_ACCESS && t_dhcp[hidx]
    |=> hdr_valid_o && hdr_o.relay && hdr_o.opt_code == vca_pkg::OPT82_CODE;
  endproperty
  a_dhcp_relay: assert property (p_dhcp_relay)
    else $error("DHCP discover left without relay option");

  property p_relay_off;
    @(posedge clock_i) disable iff (!rst_n)
    go && hdr_i.kind == vca_pkg::KIND_DHCP_DISC && !t_dhcp[hidx]
    |=> !hdr_o.relay;
  endproperty
  a_relay_off: assert property (p_relay_off)
    else $error("relay option written while disabled");

  property p_circ_empty;
    @(posedge clock_i) disable iff (!rst_n)
    hdr_valid_o && hdr_o.relay |-> hdr_o.circ_id_len == 8'h00 &&
      hdr_o.opt_len == vca_pkg::OPT_NEW_LEN && hdr_o.csum_fix;
  endproperty
  a_circ_empty: assert property (p_circ_empty)
    else $error("relay option layout wrong");

  property p_remote_identifier;
    @(posedge clock_i) disable iff (!rst_n)
    go && relay_c |=> hdr_o.remote_identifier == {$past(prefix), $past(t_sid[hidx])};
  endproperty
  a_remote_identifier: assert property (p_remote_identifier)
    else $error("remote identifier not the service id");

  property p_padi;
    @(posedge clock_i) disable iff (!rst_n)
    go && !drop_c && hdr_i.kind == vca_pkg::KIND_PADI && t_pppoe[hidx] &&
    !hdr_i.dir && t_mode[hidx] == vca_pkg::MODE_ACCESS |=> hdr_o.relay;
  endproperty
  a_padi: assert property (p_padi)
    else $error("PADI left without identifiers");

  property p_strip;
    @(posedge clock_i) disable iff (!rst_n)
    go && !drop_c && hdr_i.dir && t_mode[hidx] == vca_pkg::MODE_PASS
    |=> !hdr_o.tag_outer && !hdr_o.drop;
  endproperty
  a_strip: assert property (p_strip)
    else $error("outer tag kept toward passthrough port");

  property p_untagged;
    @(posedge clock_i) disable iff (!rst_n)
    go && hdr_i.dir && !hdr_i.has_outer |=> hdr_o.drop;
  endproperty
  a_untagged: assert property (p_untagged)
    else $error("untagged network frame forwarded");

  property p_dscp;
    @(posedge clock_i) disable iff (!rst_n)
    go |=> hdr_valid_o && hdr_o.dscp == $past(hdr_i.dscp);
  endproperty
  a_dscp: assert property (p_dscp)
    else $error("DSCP changed");

  property p_inner_range;
    @(posedge clock_i) disable iff (!rst_n)
    ce_i && commit && stg_cfg[0] && s_mode == vca_pkg::MODE_ACCESS &&
    s_inner > vca_pkg::INNER_MAX |=> irq_stat[vca_pkg::IRQ_REJECT_BIT];
  endproperty
  a_inner_range: assert property (p_inner_range)
    else $error("inner tag above 4000 accepted");

  c_relay: cover property (@(posedge clock_i) disable iff (!rst_n)
    hdr_valid_o && hdr_o.relay);
  c_drop:  cover property (@(posedge clock_i) disable iff (!rst_n)
    go && drop_c && hdr_i.dir);
  c_pass:  cover property (@(posedge clock_i) disable iff (!rst_n)
    go && !drop_c && t_mode[hidx] == vca_pkg::MODE_PASS);

endmodule : vca_top

//--- vca_peer.sv
`timescale 1ns/10ps
// **********
// Parser-side partner: issues headers, catches edited ones
// **********
module vca_peer (
  input  wire logic                  clock_i,
  output logic                       hdr_valid_o,
  output vca_pkg::vca_hdr_in_t       hdr_o,
  input  wire logic                  hdr_valid_i,
  input  wire vca_pkg::vca_hdr_out_t hdr_i
);
  vca_pkg::vca_hdr_out_t got; // Last edited header caught
  initial {hdr_valid_o, hdr_o} = '0; // Idle from time zero
  // One-cycle strobe; bus inverted after so stale data cannot pass
  task automatic send(input vca_pkg::vca_hdr_in_t h);
    got = '1; // Poisoned until the answer lands
    @(posedge clock_i);
    {hdr_valid_o, hdr_o} <= {1'b1, h};
    @(posedge clock_i);
    {hdr_valid_o, hdr_o} <= {1'b0, ~h};
    repeat (4) begin
      @(posedge clock_i);
      if (hdr_valid_i === 1'b1)
        got = hdr_i;
    end
  endtask : send
endmodule : vca_peer

//--- tb_top.sv
`timescale 1ns/10ps
// **********
// Bench: table set-up over APB, then header traffic
// **********
module tb_top;
  logic                  clock_i = 1'b0;   // 25 MHz
  logic                  resetn_i = 1'b0;  // Low for 4 cycles
  logic                  psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]            paddr = 8'h00;
  logic [31:0]           pwdata = 32'h0, prdata, rd;
  logic                  pready, pslverr, err, irq, hv_i, hv_o;
  vca_pkg::vca_hdr_in_t  hin;
  vca_pkg::vca_hdr_out_t hout, g;          // g: last answer
  int                    n_mismatch = 0, n_checks = 0;
  // Address/data pairs: access entry, passthrough entry, bad entry
  // Fourth entry: many-to-one circuit on outer tag 0x400, user port 3
  logic [39:0] cfg [20] = '{40'h10_0000_0000, 40'h14_0100_0005,
    40'h18_0000_0103, 40'h1c_3333_3333, 40'h20_2222_2222,
    40'h24_1111_1111, 40'h28_00ab_cdef, 40'h2c_0000_0001,
    40'h10_0000_0001, 40'h14_0200_0000, 40'h18_0000_0211,
    40'h2c_0000_0001, 40'h10_0000_0002, 40'h14_0300_0000,
    40'h18_0000_0001, 40'h2c_0000_0001, 40'h10_0000_0003,
    40'h14_0400_0000, 40'h18_0000_0321, 40'h2c_0000_0001};
  always #20 clock_i = ~clock_i; // 40 ns period
  // Small table depth keeps the run short
  vca_top #(.NCIRC(4)) vca_top_inst (
    .clock_i(clock_i), .resetn_i(resetn_i), .ce_i(1'b1), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .hdr_valid_i(hv_i), .hdr_i(hin),
    .hdr_valid_o(hv_o), .hdr_o(hout), .irq_o(irq));
  vca_peer vca_peer_inst (.clock_i(clock_i), .hdr_valid_o(hv_i),
    .hdr_o(hin), .hdr_valid_i(hv_o), .hdr_i(hout));
  // Compare and count
  task automatic chk(input logic [119:0] seen, input logic [119:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer; data and error taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clock_i);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clock_i);
    penable <= 1'b1;
    // Slave sets the pace; only the watchdog ends a hang
    while (pready !== 1'b1)
      @(posedge clock_i);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask : apb
  // One header from user port 1, inner tag 5, old option 8 bytes
  task automatic frm(input logic d, input logic [11:0] o,
                     input vca_pkg::vca_kind_t k);
    vca_peer_inst.send('{dir:d, port:4'h1, has_outer:d, outer_vid:o,
      has_inner:1'b1, inner_vid:12'h005, kind:k, opt_len:8'h08,
      pkt_len:16'h012c, dscp:6'h2a});
    g = vca_peer_inst.got;
  endtask : frm
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // Watchdog, far beyond the 150 or so cycles needed
  initial begin
    #400000;
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    repeat (4) @(posedge clock_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'hfc, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    for (int i = 0; i < 20; i++)
      apb(1'b1, cfg[i][39:32], cfg[i][31:0]);
    apb(1'b0, 8'h04, 32'h0);
    chk({rd[2:0], irq}, {3'h4, 1'b0});
    apb(1'b1, 8'h08, 32'h1);
    apb(1'b1, 8'h04, 32'h4);
    apb(1'b1, 8'h00, 32'h1);
    $display("test config done");
    frm(1'b0, 12'h000, vca_pkg::KIND_DHCP_DISC);
    chk({g.relay, g.opt_code, g.opt_len}, {1'b1, 8'h52, 8'h13});
    chk({g.circ_id_len, g.drop}, {8'h00, 1'b0});
    chk(g.remote_identifier, {24'habcdef, 96'h1111_1111_2222_2222_3333_3333});
    chk({g.pkt_len, g.csum_fix, g.dscp}, {16'h0137, 1'b1, 6'h2a});
    chk({g.tag_outer, g.outer_vid, g.inner_vid}, {13'h1100, 12'h005});
    frm(1'b0, 12'h000, vca_pkg::KIND_PADI);
    chk(g.relay, 1'b0);
    $display("test relay done");
    frm(1'b1, 12'h200, vca_pkg::KIND_OTHER);
    chk({g.drop, g.tag_outer, g.dscp}, {2'b00, 6'h2a});
    frm(1'b1, 12'h400, vca_pkg::KIND_OTHER);
    chk({g.drop, g.tag_outer, g.outer_vid}, {2'b01, 12'h400});
    frm(1'b1, 12'h7ff, vca_pkg::KIND_OTHER);
    chk({g.drop, irq}, 2'b11);
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b0, 8'h0c, 32'h0);
    chk({rd, irq}, {32'h1, 1'b0});
    $display("test network side done");
    report_and_stop;
  end
endmodule : tb_top
